// >>> design/emb_params.svh
// emb_params.svh: numeric constants of the external memory bus interface
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH
`define EMB_PH_FIRST 2'h0
`define EMB_PH_ALE_LOW 2'h2
`define EMB_PH_ADDR_OFF 2'h3
`define EMB_PH_LAST 2'h3
`define EMB_PH_STEP 2'h1
`define EMB_MC_NONE 3'h0
`define EMB_MC_STEP 3'h1
`define EMB_XRAM_LIMIT 16'h0400
`define EMB_XRAM_AW 10
`define EMB_XRAM_DEPTH 1024
`define EMB_OP_DEC_PTR 8'hA5
`define EMB_PTR_STEP 16'h0001
`define EMB_PTR_RST 16'h0000
`define EMB_BYTE_RST 8'h00
`define EMB_XRAM_EN_RST 1'b0
`define EMB_SYNC_RST 3'h7
`endif

// >>> design/emb_pkg.sv
// emb_pkg.sv: types of the external memory bus interface
package emb_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_addr = 4'h2,
    st_strb = 4'h4,
    st_done = 4'h8
  } emb_state_t;
  typedef enum logic [1:0] {
    acc_fetch = 2'h0,
    acc_code_read = 2'h1,
    acc_xdata_read = 2'h2,
    acc_xdata_write = 2'h3
  } emb_acc_t;
endpackage

// >>> design/emb_data_pointer_if.sv
// emb_data_pointer_if.sv: carrier between bus top and the data pointer pair
`timescale 1ns/1ps
interface emb_ptr_if;
  logic sel;
  logic load;
  logic inc;
  logic dec;
  logic [15:0] load_val;
  logic [15:0] value;
  modport ctrl(output sel, output load, output inc, output dec, output load_val, input value);
  modport unit(input sel, input load, input inc, input dec, input load_val, output value);
endinterface

// >>> design/emb_data_pointer.sv
// emb_data_pointer.sv: pair of data pointers with load, increment and decrement
`timescale 1ns/1ps
`include "emb_params.svh"
module emb_ptr_pair
  import emb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  emb_ptr_if.unit dp
);
  logic [15:0] ptr_ff [2];
  logic [15:0] nxt_ptr [2];

  // ==========================================================
  // pointer update
  always_comb begin
    nxt_ptr[0] = ptr_ff[0];
    nxt_ptr[1] = ptr_ff[1];
    if (dp.load) begin
      nxt_ptr[dp.sel] = dp.load_val;
    end else if (dp.dec) begin
      nxt_ptr[dp.sel] = ptr_ff[dp.sel] - `EMB_PTR_STEP; // [RQ13]
    end else if (dp.inc) begin
      nxt_ptr[dp.sel] = ptr_ff[dp.sel] + `EMB_PTR_STEP;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_ff[0] <= `EMB_PTR_RST;
      ptr_ff[1] <= `EMB_PTR_RST;
    end else if (i_ce) begin
      ptr_ff[0] <= nxt_ptr[0];
      ptr_ff[1] <= nxt_ptr[1];
    end
  end

  assign dp.value = ptr_ff[dp.sel]; // [RQ13]
endmodule // emb_ptr_pair

// >>> design/emb_bus_top.sv
// emb_bus_top.sv: external memory bus sequencer with on-chip data SRAM
// Function
// [RQ1] fetch strobe enables ROM onto low port
// [RQ2] address latch pulse captures low address byte
// [RQ3] reset held two machine cycles by board
// [RQ4] low address and data share one port
// [RQ5] high address byte on second port
// [RQ6] separate data store and read strobes
// [RQ7] stall input on auxiliary port bit
// [RQ8] machine cycle is four clocks
// [RQ9] data move lasts two to nine cycles
// [RQ10] 1KB on-chip SRAM at 0000H-03FFH
// [RQ11] software picks on-chip SRAM or bus
// [RQ12] code source select held low by board
// [RQ13] two pointers, opcode A5H decrements active
// [RQ14] enabled SRAM: above 03FFH goes external
// [RQ15] reset clears on-chip SRAM enable
// [RQ16] wait enabled makes stall bit input only
// [RQ17] address off port after latch falls
// [RQ18] stall holds strobe and delays completion
`timescale 1ns/1ps
`include "emb_params.svh"
module emb_bus_top
  import emb_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_req,
  input wire logic [1:0] i_kind,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic o_ready,
  output logic o_ack,
  output logic [7:0] o_rdata,
  input wire logic [2:0] i_stretch,
  input wire logic i_wait_enable,
  input wire logic i_xram_en_wr,
  input wire logic i_xram_en_val,
  output logic o_xram_en,
  input wire logic i_dp_sel,
  input wire logic i_dp_load,
  input wire logic [15:0] i_dp_load_val,
  input wire logic i_dp_inc,
  input wire logic i_op_valid,
  input wire logic [7:0] i_opcode,
  output logic [15:0] o_data_pointer,
  input wire logic i_code_source_select,
  output logic o_ale,
  output logic o_program_fetch_strobe_b,
  output logic o_rd_b,
  output logic o_wr_b,
  input wire logic [7:0] i_p0,
  output logic [7:0] o_p0,
  output logic o_p0_oe_b,
  output logic [7:0] o_p2,
  input wire logic i_p4_0,
  output logic o_p4_0_oe_b
);
  // ==========================================================
  // state
  emb_state_t state_ff, nxt_state;
  emb_acc_t kind_ff, nxt_kind;
  logic [1:0] ph_ff, nxt_ph;
  logic [2:0] mc_ff, nxt_mc;
  logic [15:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic [7:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack;
  logic xram_en_ff, nxt_xram_en;
  logic [2:0] wait_sync_ff, nxt_wait_sync;
  logic stall_ff, nxt_stall;
  logic [7:0] p0_s1_ff, p0_s2_ff, p0_s3_ff;
  logic mem_we;
  logic [`EMB_XRAM_AW-1:0] mem_idx;
  logic [7:0] xram [`EMB_XRAM_DEPTH];
  logic is_move;
  logic onchip_hit;
  logic stall_now;

  emb_ptr_if dpi();

  // ==========================================================
  // data pointers
  always_comb begin
    dpi.sel = i_dp_sel;
    dpi.load = i_dp_load;
    dpi.load_val = i_dp_load_val;
    dpi.inc = i_dp_inc;
    dpi.dec = i_op_valid && (i_opcode == `EMB_OP_DEC_PTR); // [RQ13]
  end

  emb_ptr_pair u_ptr (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .dp(dpi.unit)
  );

  assign o_data_pointer = dpi.value;

  // ==========================================================
  // pin synchronisers
  // a pin change counts only once stages two and three agree
  always_comb begin
    nxt_wait_sync = {wait_sync_ff[1:0], i_p4_0};
    nxt_stall = stall_ff;
    if (wait_sync_ff[1] == wait_sync_ff[2]) begin
      nxt_stall = !wait_sync_ff[2]; // [RQ7]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_sync_ff <= `EMB_SYNC_RST;
      stall_ff <= 1'b0;
      p0_s1_ff <= `EMB_BYTE_RST;
      p0_s2_ff <= `EMB_BYTE_RST;
      p0_s3_ff <= `EMB_BYTE_RST;
    end else if (i_ce) begin
      wait_sync_ff <= nxt_wait_sync;
      stall_ff <= nxt_stall;
      p0_s1_ff <= i_p0;
      p0_s2_ff <= p0_s1_ff;
      p0_s3_ff <= p0_s2_ff;
    end
  end

  // ==========================================================
  // bus sequencer
  assign is_move = (i_kind == acc_xdata_read) || (i_kind == acc_xdata_write);
  assign onchip_hit = is_move && xram_en_ff && (i_addr < `EMB_XRAM_LIMIT); // [RQ10] [RQ14]
  assign stall_now = i_wait_enable && stall_ff &&
                     ((kind_ff == acc_xdata_read) || (kind_ff == acc_xdata_write));
  assign mem_idx = i_addr[`EMB_XRAM_AW-1:0];

  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_ph = ph_ff;
    nxt_mc = mc_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_ack = 1'b0;
    nxt_xram_en = xram_en_ff;
    mem_we = 1'b0;
    if (i_xram_en_wr) begin
      nxt_xram_en = i_xram_en_val; // [RQ11]
    end
    case (state_ff)
      st_idle: begin
        if (i_req) begin
          nxt_kind = emb_acc_t'(i_kind);
          nxt_addr = i_addr;
          nxt_wdata = i_wdata;
          if (onchip_hit) begin
            // on-chip hit pulses no strobe or latch, only o_p2 follows the address; answers next cycle
            nxt_ack = 1'b1;
            if (i_kind == acc_xdata_write) begin
              mem_we = 1'b1; // [RQ10]
            end else begin
              nxt_rdata = xram[mem_idx];
            end
          end else begin
            nxt_state = st_addr;
            nxt_ph = `EMB_PH_FIRST;
            // fetches take one strobe cycle; moves 1 + stretch
            nxt_mc = is_move ? i_stretch : `EMB_MC_NONE; // [RQ9]
          end
        end
      end
      st_addr: begin
        nxt_ph = ph_ff + `EMB_PH_STEP; // [RQ8]
        if (ph_ff == `EMB_PH_LAST) begin
          nxt_state = st_strb;
        end
      end
      st_strb: begin
        nxt_ph = ph_ff + `EMB_PH_STEP; // [RQ8]
        // a write drives the port itself, so the last read byte must survive it
        if ((kind_ff != acc_xdata_write) && (p0_s2_ff == p0_s3_ff)) begin
          nxt_rdata = p0_s3_ff; // [RQ1]
        end
        if (ph_ff == `EMB_PH_LAST) begin
          if (mc_ff != `EMB_MC_NONE) begin
            nxt_mc = mc_ff - `EMB_MC_STEP; // [RQ9]
          end else if (!stall_now) begin
            nxt_state = st_done; // [RQ18]
          end
        end
      end
      st_done: begin
        nxt_ack = 1'b1;
        nxt_state = st_idle;
      end
      default: begin
        nxt_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= st_idle;
      kind_ff <= acc_fetch;
      ph_ff <= `EMB_PH_FIRST;
      mc_ff <= `EMB_MC_NONE;
      addr_ff <= `EMB_PTR_RST;
      wdata_ff <= `EMB_BYTE_RST;
      rdata_ff <= `EMB_BYTE_RST;
      ack_ff <= 1'b0;
      xram_en_ff <= `EMB_XRAM_EN_RST; // [RQ15]
    end else if (i_ce) begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      ph_ff <= nxt_ph;
      mc_ff <= nxt_mc;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      xram_en_ff <= nxt_xram_en;
    end
  end

  // storage is not reset: contents are undefined after power-up
  always_ff @(posedge i_mclk) begin
    if (i_ce && mem_we) begin
      xram[mem_idx] <= i_wdata;
    end
  end

  // ==========================================================
  // pins
  always_comb begin
    o_ready = (state_ff == st_idle);
    o_ack = ack_ff;
    o_rdata = rdata_ff;
    o_xram_en = xram_en_ff;
    o_ale = (state_ff == st_addr) && (ph_ff < `EMB_PH_ALE_LOW); // [RQ2]
    o_p2 = addr_ff[15:8]; // [RQ5]
    o_p0 = wdata_ff;
    o_p0_oe_b = 1'b1;
    // address stays one clock past the latch fall for hold, then floats
    if ((state_ff == st_addr) && (ph_ff < `EMB_PH_ADDR_OFF)) begin
      o_p0 = addr_ff[7:0]; // [RQ4] [RQ17]
      o_p0_oe_b = 1'b0;
    end else if ((state_ff == st_strb) && (kind_ff == acc_xdata_write)) begin
      o_p0_oe_b = 1'b0; // [RQ4]
    end
    o_program_fetch_strobe_b = !((state_ff == st_strb) &&
                                 ((kind_ff == acc_fetch) || (kind_ff == acc_code_read))); // [RQ1]
    o_rd_b = !((state_ff == st_strb) && (kind_ff == acc_xdata_read)); // [RQ6]
    o_wr_b = !((state_ff == st_strb) && (kind_ff == acc_xdata_write)); // [RQ6]
    // the general port function is outside this block, so the bit is never driven
    o_p4_0_oe_b = 1'b1; // [RQ16]
  end
endmodule // emb_bus_top

// >>> test/emb_bus_top_asserts.sv
// emb_bus_top_asserts.sv: strobe, port and timing checker of the external bus
`timescale 1ns/1ps
module emb_chk (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic o_ready,
  input wire logic o_ack,
  input wire logic o_ale,
  input wire logic o_program_fetch_strobe_b,
  input wire logic o_rd_b,
  input wire logic o_wr_b,
  input wire logic o_p0_oe_b,
  input wire logic o_p4_0_oe_b
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // ==========================================
  // port direction against strobes
  strb_excl_a: assert property (o_rd_b || o_wr_b) else $error("read and write both low");
  rd_float_a: assert property (!o_rd_b |-> o_p0_oe_b) else $error("low port driven in read");
  fetch_float_a: assert property (!o_program_fetch_strobe_b |-> o_p0_oe_b)
    else $error("low port driven in fetch");
  wr_drive_a: assert property (!o_wr_b |-> !o_p0_oe_b) else $error("write data not driven");
  ale_drive_a: assert property (o_ale |-> !o_p0_oe_b) else $error("address not driven");
  wait_in_a: assert property (o_p4_0_oe_b) else $error("stall pin driven");
  // ==========================================
  // machine cycle timing
  ale_width_a: assert property ($rose(o_ale) |=> o_ale ##1 !o_ale) else $error("latch width");
  addr_gap_a: assert property ($fell(o_ale) |=> o_p0_oe_b) else $error("address held");
  fetch_len_a: assert property ($fell(o_program_fetch_strobe_b) |->
    !o_program_fetch_strobe_b [*4] ##1 o_program_fetch_strobe_b ##1 o_ack) else $error("fetch len");
  rd_min_a: assert property ($fell(o_rd_b) |-> !o_rd_b [*4]) else $error("read too short");
  ack_idle_a: assert property (o_ack |-> o_ready) else $error("ack while busy");
  cover property ($fell(o_program_fetch_strobe_b));
  cover property ($fell(o_rd_b));
  cover property ($fell(o_wr_b));
endmodule // emb_chk

bind emb_bus_top emb_chk i_chk (.i_mclk, .i_rst_b, .o_ready, .o_ack, .o_ale,
  .o_program_fetch_strobe_b, .o_rd_b, .o_wr_b, .o_p0_oe_b, .o_p4_0_oe_b);

// >>> test/emb_mem_model.sv
// emb_mem_model.sv: external program and data memory with address latch and stall pin
`timescale 1ns/1ps
module emb_mem_model (
  input wire logic i_mclk,
  input wire logic i_ale,
  input wire logic i_fetch_b,
  input wire logic i_rd_b,
  input wire logic i_wr_b,
  input wire logic [7:0] i_ad,
  input wire logic [7:0] i_ah,
  input wire logic i_stall,
  output logic [7:0] o_ad,
  output logic o_wait_b
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat;
  logic [7:0] last;
  initial for (int a = 0; a < 65536; a++) mem[a] = a[7:0] ^ a[15:8] ^ 8'h5A;
  // latch register samples the low port at each rising clock edge while the latch pulse is high
  always @(posedge i_mclk) if (i_ale) lat <= i_ad;
  always @(posedge i_mclk) if (!i_wr_b) mem[{i_ah, lat}] <= i_ad;
  always @(posedge i_mclk) last <= o_ad;
  // released bus toggles so a stale byte never passes as data
  assign o_ad = (!i_rd_b || !i_fetch_b) ? mem[{i_ah, lat}] : ~last;
  assign o_wait_b = !i_stall;
endmodule // emb_mem_model

// >>> test/emb_bus_top_tb_top.sv
// emb_bus_top_tb_top.sv: self-checking bench of the external memory bus
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module emb_bus_top_tb_top import emb_pkg::*; ;
  logic i_mclk = 0, i_rst_b = 0, i_ce = 1, i_req = 0, i_wait_enable = 0, i_xram_en_wr = 0;
  logic i_xram_en_val = 0, i_dp_sel = 0, i_dp_load = 0, i_dp_inc = 0, i_op_valid = 0, stall = 0;
  logic i_code_source_select = 0;
  logic [1:0] i_kind = 0;
  logic [15:0] i_addr = 0, i_dp_load_val = 16'h0100, o_data_pointer;
  logic [7:0] i_wdata = 0, i_opcode = 8'hA5, o_rdata, o_p0, o_p2, m_ad, rd, d, p;
  logic [2:0] i_stretch = 0;
  logic o_ready, o_ack, o_xram_en, o_ale, o_program_fetch_strobe_b, o_rd_b, o_wr_b;
  logic o_p0_oe_b, o_p4_0_oe_b, i_p4_0;
  wire logic [7:0] i_p0 = o_p0_oe_b ? m_ad : o_p0;
  int num_errors = 0, checks_done = 0, cyc = 0, n0, n;
  always #2.5 i_mclk = ~i_mclk;
  emb_bus_top i_dut (.i_mclk, .i_rst_b, .i_ce, .i_req, .i_kind, .i_addr, .i_wdata, .o_ready,
    .o_ack, .o_rdata, .i_stretch, .i_wait_enable, .i_xram_en_wr, .i_xram_en_val, .o_xram_en,
    .i_dp_sel, .i_dp_load, .i_dp_load_val, .i_dp_inc, .i_op_valid, .i_opcode, .o_data_pointer,
    .i_code_source_select, .o_ale, .o_program_fetch_strobe_b, .o_rd_b, .o_wr_b, .i_p0, .o_p0,
    .o_p0_oe_b, .o_p2, .i_p4_0, .o_p4_0_oe_b);
  emb_mem_model i_mem (.i_mclk, .i_ale(o_ale), .i_fetch_b(o_program_fetch_strobe_b),
    .i_rd_b(o_rd_b), .i_wr_b(o_wr_b), .i_ad(i_p0), .i_ah(o_p2), .i_stall(stall), .o_ad(m_ad),
    .o_wait_b(i_p4_0));
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic acc(input logic [1:0] k, input logic [15:0] a, input logic [7:0] wd,
    output int c);
    c = 0;
    i_kind = k;
    i_addr = a;
    i_wdata = wd;
    i_req = 1;
    @(posedge i_mclk);
    #1 i_req = 0;
    while (o_ack !== 1'b1 && c < 200) begin
      @(posedge i_mclk);
      #1 c++;
    end
    rd = o_rdata;
    `CHK("ack", 1'b1, o_ack)
    // one edge between requests so i_req is never lowered and raised in one step
    @(posedge i_mclk);
    #1 `CHK("ack_pulse", 1'b0, o_ack)
    `CHK("ready", 1'b1, o_ready)
  endtask
  task automatic en_xram(input logic v);
    i_xram_en_val = v;
    i_xram_en_wr = 1;
    @(posedge i_mclk);
    #1 i_xram_en_wr = 0;
    `CHK("xram_en", v, o_xram_en)
  endtask
  task automatic dp(input logic l, input logic u, input logic v, input logic [15:0] e);
    i_dp_load = l;
    i_dp_inc = u;
    i_op_valid = v;
    @(posedge i_mclk);
    #1 {i_dp_load, i_dp_inc, i_op_valid} = 3'h0;
    @(posedge i_mclk);
    #1 `CHK("ptr", e, o_data_pointer)
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    `CHK("xram_en_rst", 1'b0, o_xram_en)
    `CHK("ptr_rst", 16'h0000, o_data_pointer)
    `CHK("p0_rst", 1'b1, o_p0_oe_b)
  endtask
  task automatic t_code;
    for (int k = 1; k >= 0; k--) begin
      acc(k[1:0], 16'hA512, 8'h00, n0);
      `CHK("code", pat(16'hA512), rd)
      `CHK("p2", 8'hA5, o_p2)
      `CHK("latch", 8'h12, i_mem.lat)
    end
  endtask
  task automatic t_move;
    for (int s = 0; s < 8; s += 7) begin
      i_stretch = s[2:0];
      d = 8'hC3 ^ s[7:0];
      p = rd;
      acc(acc_xdata_write, 16'h4321, d, n);
      `CHK("rd_hold", p, rd)
      `CHK("wr_len", n0 + 4 * s, n)
      `CHK("ext_wr", d, i_mem.mem[16'h4321])
      acc(acc_xdata_read, 16'h4321, 8'h00, n);
      `CHK("ext_rd", d, rd)
      `CHK("rd_len", n0 + 4 * s, n)
    end
    i_stretch = 0;
  endtask
  task automatic t_xram;
    en_xram(1);
    acc(acc_xdata_write, 16'h03FF, 8'h3C, n);
    `CHK("no_ext", pat(16'h03FF), i_mem.mem[16'h03FF])
    acc(acc_xdata_read, 16'h03FF, 8'h00, n);
    `CHK("on_rd", 8'h3C, rd)
    `CHK("on_fast", 1'b1, n < 2)
    acc(acc_xdata_write, 16'h0400, 8'h96, n);
    `CHK("above", 8'h96, i_mem.mem[16'h0400])
    en_xram(0);
    acc(acc_xdata_read, 16'h03FF, 8'h00, n);
    `CHK("off_rd", pat(16'h03FF), rd)
  endtask
  task automatic t_stall;
    i_wait_enable = 1;
    stall = 1;
    fork
      acc(acc_xdata_read, 16'h4321, 8'h00, n);
      begin
        repeat (10) @(posedge i_mclk);
        #1 stall = 0;
      end
    join
    `CHK("stall_len", 1'b1, n > n0 && (n - n0) % 4 == 0)
    `CHK("stall_rd", 8'hC4, rd)
    i_wait_enable = 0;
    stall = 1;
    acc(acc_xdata_read, 16'h4321, 8'h00, n);
    `CHK("no_wait", n0, n)
    stall = 0;
  endtask
  task automatic t_data_pointer;
    dp(1, 0, 0, 16'h0100);
    dp(0, 0, 1, 16'h00FF);
    dp(0, 1, 0, 16'h0100);
    // a held-off clock enable must swallow the increment
    i_ce = 0;
    dp(0, 1, 0, 16'h0100);
    i_ce = 1;
    i_dp_sel = 1;
    #1 `CHK("ptr_other", 16'h0000, o_data_pointer)
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // held well past two machine cycles
  initial begin
    repeat (16) @(posedge i_mclk);
    #1 i_rst_b = 1;
    t_reset;
    t_code;
    t_move;
    t_xram;
    t_stall;
    t_data_pointer;
    end_sim;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim;
    end
  end
endmodule // emb_bus_top_tb_top
